// *** logic/cbr_block_ram.sv ***
// file: configurable 18-kbit block ram core with two ports and optional preload
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - 18 kbit storage, registered input and output stages, each with clock enable
// - aspect ratios 16k x 1 to 1k x 18 everywhere; 512 x 36 not true dual
// - modes: single port, true dual port, pseudo dual port, read only
// - optional ninth parity bit stored beside each data byte
// - at 18 and 36 bit widths, per-byte write enables gate writes
// - in multi-port modes each port picks its own width
// - word 0 fills the lowest bits lsb first, then word 1, every port
// - contents may be preloaded at configuration, present when operation begins
// - read only use needs preload and disabled writes; reads return preload
module cbr_block_ram
    import cbr_pkg::*;
#(
    parameter cbr_mode_e  MODE       = CBR_TRUE_DUAL,
    parameter cbr_width_e WIDTH_A    = CBR_W18,
    parameter cbr_width_e WIDTH_B    = CBR_W18,
    parameter bit         PARITY_EN  = 1'b1,
    parameter string      INIT_FILE  = "",
    parameter logic [cbr_pkg::CBR_TOTAL_BITS-1:0] INIT_BITS = '0
) (
    input  wire logic                            i_clk,
    input  wire logic                            i_reset_n,
    input  wire logic                            i_a_in_ce,
    input  wire logic                            i_a_out_ce,
    input  wire logic                            i_a_en,
    input  wire logic                            i_a_we,
    input  wire logic [cbr_pkg::CBR_ADDR_W-1:0]  i_a_addr,
    input  wire logic [cbr_pkg::CBR_DATA_W-1:0]  i_a_wdata,
    input  wire logic [cbr_pkg::CBR_BE_W-1:0]    i_a_be,
    output logic      [cbr_pkg::CBR_DATA_W-1:0]  o_a_rdata,
    input  wire logic                            i_b_in_ce,
    input  wire logic                            i_b_out_ce,
    input  wire logic                            i_b_en,
    input  wire logic                            i_b_we,
    input  wire logic [cbr_pkg::CBR_ADDR_W-1:0]  i_b_addr,
    input  wire logic [cbr_pkg::CBR_DATA_W-1:0]  i_b_wdata,
    input  wire logic [cbr_pkg::CBR_BE_W-1:0]    i_b_be,
    output logic      [cbr_pkg::CBR_DATA_W-1:0]  o_b_rdata
);
    import cbr_pkg::*;

    // =====================================================================
    // elaboration checks
    localparam bit RATIO_OK = cbr_width_legal(MODE, WIDTH_A) && cbr_width_legal(MODE, WIDTH_B);

    if (!RATIO_OK) begin : g_bad_ratio
        $error("cbr_block_ram: 512 x 36 not available in true dual port");
    end
    if (MODE == CBR_SINGLE && WIDTH_B != WIDTH_A) begin : g_bad_single
        $error("cbr_block_ram: single port uses one width");
    end
    // a file loader would be a second writer of the storage; only the vector is served
    if (INIT_FILE != "") begin : g_no_file
        $error("cbr_block_ram: preload from a file not served, use INIT_BITS");
    end

    localparam int unsigned WA = cbr_width_bits(WIDTH_A);
    localparam int unsigned WB = cbr_width_bits(WIDTH_B);

    // storage is a flat bit vector so that both ports see the same bit order
    // preload at configuration: the only state that starts from a given value
    logic [CBR_TOTAL_BITS-1:0] mem_r = INIT_BITS;
    logic [CBR_TOTAL_BITS-1:0] mem_nxt;

    // =====================================================================
    // registered input stages
    logic                  a_en, a_we, b_en, b_we;
    logic [CBR_ADDR_W-1:0] a_addr, b_addr;
    logic [CBR_DATA_W-1:0] a_wdata, b_wdata;
    logic [CBR_BE_W-1:0]   a_be, b_be;

    cbr_port_stage #(.ADDR_W(CBR_ADDR_W), .DATA_W(CBR_DATA_W), .BE_W(CBR_BE_W)) u_stage_a (
        .i_clk    (i_clk),
        .i_reset_n(i_reset_n),
        .i_ce     (i_a_in_ce),
        .i_en     (i_a_en),
        .i_we     (i_a_we),
        .i_addr   (i_a_addr),
        .i_wdata  (i_a_wdata),
        .i_be     (i_a_be),
        .o_en     (a_en),
        .o_we     (a_we),
        .o_addr   (a_addr),
        .o_wdata  (a_wdata),
        .o_be     (a_be)
    );

    cbr_port_stage #(.ADDR_W(CBR_ADDR_W), .DATA_W(CBR_DATA_W), .BE_W(CBR_BE_W)) u_stage_b (
        .i_clk    (i_clk),
        .i_reset_n(i_reset_n),
        .i_ce     (i_b_in_ce),
        .i_en     (i_b_en),
        .i_we     (i_b_we),
        .i_addr   (i_b_addr),
        .i_wdata  (i_b_wdata),
        .i_be     (i_b_be),
        .o_en     (b_en),
        .o_we     (b_we),
        .o_addr   (b_addr),
        .o_wdata  (b_wdata),
        .o_be     (b_be)
    );

    // =====================================================================
    // port behaviour per mode
    logic a_wr_ok, b_wr_ok, b_rd_ok;

    always_comb begin
        unique case (MODE)
            CBR_SINGLE:      begin a_wr_ok = 1'b1; b_wr_ok = 1'b0; b_rd_ok = 1'b0; end
            CBR_TRUE_DUAL:   begin a_wr_ok = 1'b1; b_wr_ok = 1'b1; b_rd_ok = 1'b1; end
            // pseudo dual: only port a writes, port a and port b both read
            CBR_PSEUDO_DUAL: begin a_wr_ok = 1'b1; b_wr_ok = 1'b0; b_rd_ok = 1'b1; end
            // write controls disabled in hardware so preload cannot be disturbed
            CBR_ROM:         begin a_wr_ok = 1'b0; b_wr_ok = 1'b0; b_rd_ok = 1'b1; end
            default:         begin a_wr_ok = 1'b0; b_wr_ok = 1'b0; b_rd_ok = 1'b0; end
        endcase
    end

    // per-bit write mask; byte lanes only exist at 18 and 36 bits
    function automatic logic [CBR_DATA_W-1:0] lane_mask(int unsigned w,
                                                        logic [CBR_BE_W-1:0] be);
        logic [CBR_DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < CBR_DATA_W; i++) begin
            if (i < w) begin
                m[i] = (w >= 18) ? be[i / CBR_BYTE_PAR_W] : 1'b1;
            end
        end
        return m;
    endfunction : lane_mask

    // strips the parity position of each 9-bit lane when parity is off
    function automatic logic [CBR_DATA_W-1:0] par_mask(int unsigned w);
        logic [CBR_DATA_W-1:0] m;
        m = '1;
        if (!PARITY_EN && w >= CBR_BYTE_PAR_W) begin
            for (int i = 0; i < CBR_DATA_W; i++) begin
                if ((i % CBR_BYTE_PAR_W) == CBR_BYTE_W) begin
                    m[i] = 1'b0;
                end
            end
        end
        return m;
    endfunction : par_mask

    localparam logic [CBR_DATA_W-1:0] PMASK_A = par_mask(WA);
    localparam logic [CBR_DATA_W-1:0] PMASK_B = par_mask(WB);

    // =====================================================================
    // storage update; port b applied last, same-address clash is the user's to avoid
    always_comb begin
        int unsigned base;
        logic [CBR_DATA_W-1:0] mk;
        base    = 0;
        mk      = '0;
        mem_nxt = mem_r;
        if (a_en && a_we && a_wr_ok) begin
            base = 32'(a_addr) * WA;
            mk   = lane_mask(WA, a_be) & PMASK_A;
            for (int i = 0; i < CBR_DATA_W; i++) begin
                if (mk[i] && (base + i) < CBR_TOTAL_BITS) begin
                    mem_nxt[base + i] = a_wdata[i];
                end
            end
        end
        if (b_en && b_we && b_wr_ok) begin
            base = 32'(b_addr) * WB;
            mk   = lane_mask(WB, b_be) & PMASK_B;
            for (int i = 0; i < CBR_DATA_W; i++) begin
                if (mk[i] && (base + i) < CBR_TOTAL_BITS) begin
                    mem_nxt[base + i] = b_wdata[i];
                end
            end
        end
    end

    // no reset on storage: contents survive reset, as a preloaded array must
    always_ff @(posedge i_clk) begin
        mem_r <= mem_nxt;
    end

    function automatic logic [CBR_DATA_W-1:0] read_word(logic [CBR_TOTAL_BITS-1:0] m,
                                                        logic [CBR_ADDR_W-1:0] a,
                                                        int unsigned w,
                                                        logic [CBR_DATA_W-1:0] pm);
        logic [CBR_DATA_W-1:0] d;
        int unsigned b;
        d = '0;
        b = 32'(a) * w;
        for (int i = 0; i < CBR_DATA_W; i++) begin
            if (i < w && (b + i) < CBR_TOTAL_BITS) begin
                d[i] = m[b + i] & pm[i];
            end
        end
        return d;
    endfunction : read_word

    // =====================================================================
    // read latch and registered output stage (read-before-write)
    logic [CBR_DATA_W-1:0] a_lat_r, a_lat_nxt, b_lat_r, b_lat_nxt;
    logic [CBR_DATA_W-1:0] a_out_r, a_out_nxt, b_out_r, b_out_nxt;
    logic [CBR_DATA_W-1:0] a_rd_word, b_rd_word;

    always_comb begin
        a_rd_word = read_word(mem_r, a_addr, WA, PMASK_A);
        b_rd_word = read_word(mem_r, b_addr, WB, PMASK_B);
        a_lat_nxt = a_en ? a_rd_word : a_lat_r;
        b_lat_nxt = (b_en && b_rd_ok) ? b_rd_word : b_lat_r;
        a_out_nxt = i_a_out_ce ? a_lat_r : a_out_r;
        b_out_nxt = i_b_out_ce ? b_lat_r : b_out_r;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            a_lat_r <= '0;
            b_lat_r <= '0;
            a_out_r <= '0;
            b_out_r <= '0;
        end else begin
            a_lat_r <= a_lat_nxt;
            b_lat_r <= b_lat_nxt;
            a_out_r <= a_out_nxt;
            b_out_r <= b_out_nxt;
        end
    end

    assign o_a_rdata = a_out_r;
    assign o_b_rdata = b_out_r;

    // =====================================================================
    // assertions
    sequence s_a_write_stage;
        a_en && a_we && a_wr_ok;
    endsequence

    a_rom_no_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (MODE == CBR_ROM) |=> $stable(mem_r))
        else $error("rom contents changed");

    a_idle_keeps_mem: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!(a_en && a_we && a_wr_ok) && !(b_en && b_we && b_wr_ok)) |=> $stable(mem_r))
        else $error("storage changed without a write");

    a_rd_latency_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (a_en && !a_we && i_a_out_ce) ##1 i_a_out_ce
        |=> o_a_rdata == $past(a_rd_word, CBR_READ_LATENCY))
        else $error("port a read data wrong after two stages");

    a_out_ce_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_a_out_ce |=> $stable(o_a_rdata))
        else $error("port a output moved with clock enable low");

    a_byte_lane_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_a_write_stage and (WA >= 18) && !a_be[0] && !(b_en && b_we && b_wr_ok))
        |=> (read_word(mem_r, $past(a_addr), WA, PMASK_A) & 36'h1ff) ==
            (read_word($past(mem_r), $past(a_addr), WA, PMASK_A) & 36'h1ff))
        else $error("disabled byte lane written");

    a_write_lands_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_a_write_stage and !(b_en && b_we && b_wr_ok))
        |=> (read_word(mem_r, $past(a_addr), WA, PMASK_A) & lane_mask(WA, $past(a_be)))
            == ($past(a_wdata) & lane_mask(WA, $past(a_be)) & PMASK_A))
        else $error("port a write not at word position");

    a_par_off_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!PARITY_EN && WA >= 9) |-> (o_a_rdata[CBR_BYTE_W] == 1'b0))
        else $error("parity bit readable with parity disabled");

    a_pdp_b_no_wr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (MODE == CBR_PSEUDO_DUAL && b_en && b_we && !(a_en && a_we)) |=> $stable(mem_r))
        else $error("pseudo dual read port wrote storage");
endmodule : cbr_block_ram
`default_nettype wire

// *** logic/cbr_pkg.sv ***
// package: geometry, modes and timing constants of the configurable block ram
package cbr_pkg;
    // =====================================================================
    // storage geometry
    localparam int unsigned CBR_TOTAL_BITS   = 18432;
    localparam int unsigned CBR_ADDR_W       = 14;
    localparam int unsigned CBR_DATA_W       = 36;
    localparam int unsigned CBR_BE_W         = 4;
    localparam int unsigned CBR_BYTE_W       = 8;
    localparam int unsigned CBR_BYTE_PAR_W   = 9;
    localparam int unsigned CBR_WIDTH_SEL_W  = 3;
    localparam int unsigned CBR_READ_LATENCY = 2;

    // =====================================================================
    // aspect ratio and port mode encodings
    typedef enum logic [2:0] {
        CBR_W1, CBR_W2, CBR_W4, CBR_W9, CBR_W18, CBR_W36
    } cbr_width_e;

    typedef enum logic [1:0] {
        CBR_SINGLE, CBR_TRUE_DUAL, CBR_PSEUDO_DUAL, CBR_ROM
    } cbr_mode_e;

    // =====================================================================
    // helpers shared by both ports
    function automatic int unsigned cbr_width_bits(cbr_width_e w);
        unique case (w)
            CBR_W1:  return 1;
            CBR_W2:  return 2;
            CBR_W4:  return 4;
            CBR_W9:  return 9;
            CBR_W18: return 18;
            CBR_W36: return 36;
            default: return 1;
        endcase
    endfunction : cbr_width_bits

    function automatic logic cbr_width_legal(cbr_mode_e m, cbr_width_e w);
        logic ok;
        ok = (w <= CBR_W36);
        if (m == CBR_TRUE_DUAL && w == CBR_W36) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : cbr_width_legal
endpackage : cbr_pkg

// *** logic/cbr_port_stage.sv ***
// file: one memory port's registered input stage with its own clock enable
`timescale 1ns/1ps
`default_nettype none
module cbr_port_stage
    import cbr_pkg::*;
#(
    parameter int unsigned ADDR_W = 14,
    parameter int unsigned DATA_W = 36,
    parameter int unsigned BE_W   = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_ce,
    input  wire logic              i_en,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [BE_W-1:0]   i_be,
    output logic                   o_en,
    output logic                   o_we,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_wdata,
    output logic [BE_W-1:0]        o_be
);
    // elaboration check: a zero-width port cannot carry an access
    if (ADDR_W == 0 || DATA_W == 0 || BE_W == 0) begin : g_bad_width
        $error("cbr_port_stage: zero width");
    end

    logic              en_r, en_nxt, we_r, we_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [BE_W-1:0]   be_r, be_nxt;

    // =====================================================================
    // input capture; a dropped clock enable holds address, data and byte enables and clears en and we
    always_comb begin
        en_nxt    = i_ce ? i_en    : 1'b0;
        we_nxt    = i_ce ? i_we    : 1'b0;
        addr_nxt  = i_ce ? i_addr  : addr_r;
        wdata_nxt = i_ce ? i_wdata : wdata_r;
        be_nxt    = i_ce ? i_be    : be_r;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en_r    <= 1'b0;
            we_r    <= 1'b0;
            addr_r  <= '0;
            wdata_r <= '0;
            be_r    <= '0;
        end else begin
            en_r    <= en_nxt;
            we_r    <= we_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            be_r    <= be_nxt;
        end
    end

    assign o_en    = en_r;
    assign o_we    = we_r;
    assign o_addr  = addr_r;
    assign o_wdata = wdata_r;
    assign o_be    = be_r;
endmodule : cbr_port_stage
`default_nettype wire

// *** tb/cbr_user_port.sv ***
// partner model: user logic that drives one memory port of the block ram
`timescale 1ns/1ps
`default_nettype none
module cbr_user_port
    import cbr_pkg::*;
(
    input  wire logic                        i_clk,
    output logic                             o_in_ce,
    output logic                             o_out_ce,
    output logic                             o_en,
    output logic                             o_we,
    output logic [cbr_pkg::CBR_ADDR_W-1:0]   o_addr,
    output logic [cbr_pkg::CBR_DATA_W-1:0]   o_wdata,
    output logic [cbr_pkg::CBR_BE_W-1:0]     o_be
);
    // =====================================================================
    // idle state
    initial begin
        o_in_ce  = 1'b1;
        o_out_ce = 1'b1;
        o_en     = 1'b0;
        o_we     = 1'b0;
        o_addr   = '0;
        o_wdata  = '0;
        o_be     = '0;
    end

    // =====================================================================
    // one request per call; callers keep the two ports off one write address
    task automatic issue(input logic ce, input logic we, input logic [CBR_ADDR_W-1:0] a,
                         input logic [CBR_DATA_W-1:0] d, input logic [CBR_BE_W-1:0] be);
        @(posedge i_clk);
        o_in_ce <= ce;
        o_en    <= 1'b1;
        o_we    <= we;
        o_addr  <= a;
        o_wdata <= d;
        o_be    <= be;
        @(posedge i_clk);
        o_in_ce <= 1'b1;
        o_en    <= 1'b0;
        o_we    <= 1'b0;
        // released lines show the inverse so stale values cannot pass
        o_addr  <= ~a;
        o_wdata <= ~d;
        o_be    <= ~be;
    endtask : issue

    task automatic set_out_ce(input logic on);
        @(posedge i_clk);
        o_out_ce <= on;
    endtask : set_out_ce
endmodule : cbr_user_port
`default_nettype wire

// *** tb/configurable_block_ram_tb.sv ***
// testbench: dual-port ram with mixed widths beside read-only and pseudo dual twins
`timescale 1ns/1ps
`default_nettype none
module configurable_block_ram_tb;
    import cbr_pkg::*;
    localparam logic [CBR_TOTAL_BITS-1:0] INIT_PAT = {512{36'h9a5c31e7b}};
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic a_ice, a_oce, a_en, a_we, b_ice, b_oce, b_en, b_we;
    logic [CBR_ADDR_W-1:0] a_ad, b_ad;
    logic [CBR_DATA_W-1:0] a_wd, b_wd, a_rd, b_rd, rom_rd, pdp_a_rd, pdp_b_rd;
    logic [CBR_BE_W-1:0] a_be, b_be;
    logic [CBR_TOTAL_BITS-1:0] shadow = INIT_PAT;
    int fails = 0;
    int checked = 0;

    always #2 i_clk = ~i_clk;

    // =====================================================================
    // partners and the three rams sharing their port wiring
    cbr_user_port port_a_i (.i_clk(i_clk), .o_in_ce(a_ice), .o_out_ce(a_oce), .o_en(a_en),
        .o_we(a_we), .o_addr(a_ad), .o_wdata(a_wd), .o_be(a_be));
    cbr_user_port port_b_i (.i_clk(i_clk), .o_in_ce(b_ice), .o_out_ce(b_oce), .o_en(b_en),
        .o_we(b_we), .o_addr(b_ad), .o_wdata(b_wd), .o_be(b_be));
    cbr_block_ram #(.MODE(CBR_TRUE_DUAL), .WIDTH_A(CBR_W18), .WIDTH_B(CBR_W9),
        .PARITY_EN(1'b1), .INIT_BITS(INIT_PAT)) cbr_block_ram_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_a_in_ce(a_ice), .i_a_out_ce(a_oce), .i_a_en(a_en),
        .i_a_we(a_we), .i_a_addr(a_ad), .i_a_wdata(a_wd), .i_a_be(a_be), .o_a_rdata(a_rd),
        .i_b_in_ce(b_ice), .i_b_out_ce(b_oce), .i_b_en(b_en), .i_b_we(b_we),
        .i_b_addr(b_ad), .i_b_wdata(b_wd), .i_b_be(b_be), .o_b_rdata(b_rd));
    // a write sent to the read-only twin must not land; its parity bits are off
    cbr_block_ram #(.MODE(CBR_ROM), .WIDTH_A(CBR_W36), .WIDTH_B(CBR_W36),
        .PARITY_EN(1'b0), .INIT_BITS(INIT_PAT)) cbr_block_ram_rom_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_a_in_ce(a_ice), .i_a_out_ce(a_oce), .i_a_en(a_en),
        .i_a_we(a_we), .i_a_addr(a_ad), .i_a_wdata(a_wd), .i_a_be(a_be), .o_a_rdata(rom_rd),
        .i_b_in_ce(b_ice), .i_b_out_ce(b_oce), .i_b_en(b_en), .i_b_we(b_we),
        .i_b_addr(b_ad), .i_b_wdata(b_wd), .i_b_be(b_be), .o_b_rdata());
    // pseudo dual twin: port b writes are refused, port b reads still served
    cbr_block_ram #(.MODE(CBR_PSEUDO_DUAL), .WIDTH_A(CBR_W18), .WIDTH_B(CBR_W9),
        .PARITY_EN(1'b1), .INIT_BITS(INIT_PAT)) cbr_block_ram_pdp_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_a_in_ce(a_ice), .i_a_out_ce(a_oce), .i_a_en(a_en),
        .i_a_we(a_we), .i_a_addr(a_ad), .i_a_wdata(a_wd), .i_a_be(a_be),
        .o_a_rdata(pdp_a_rd),
        .i_b_in_ce(b_ice), .i_b_out_ce(b_oce), .i_b_en(b_en), .i_b_we(b_we),
        .i_b_addr(b_ad), .i_b_wdata(b_wd), .i_b_be(b_be), .o_b_rdata(pdp_b_rd));

    // =====================================================================
    // shared helpers
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function automatic logic [35:0] get(input int w, input logic [13:0] a);
        logic [35:0] r;
        r = '0;
        for (int i = 0; i < w; i++) begin
            r[i] = shadow[a * w + i];
        end
        return r;
    endfunction : get

    // narrow widths write whole words, byte enables only gate 18-bit lanes
    task automatic wr(input bit pb, input logic ce, input logic [13:0] a,
                      input logic [35:0] d, input logic [3:0] be);
        int w;
        w = pb ? 9 : 18;
        if (pb) begin
            port_b_i.issue(ce, 1'b1, a, d, be);
        end else begin
            port_a_i.issue(ce, 1'b1, a, d, be);
        end
        for (int i = 0; i < w; i++) begin
            if (ce && (w < 18 || be[i / 9])) begin
                shadow[a * w + i] = d[i];
            end
        end
    endtask : wr

    task automatic rd(input bit pb, input logic [13:0] a);
        logic [35:0] exp;
        logic [35:0] rom_exp;
        exp = get(pb ? 9 : 18, a);
        // the twin has parity off, and words past its capacity read as zero
        rom_exp = (a < 14'h200) ? (INIT_PAT[(a % 512) * 36 +: 36] & 36'h7fbfdfeff) : 36'h0;
        if (pb) begin
            port_b_i.issue(1'b1, 1'b0, a, '0, '0);
        end else begin
            port_a_i.issue(1'b1, 1'b0, a, '0, '0);
        end
        repeat (2) @(posedge i_clk);
        #1;
        check(pb ? "b_rdata" : "a_rdata", pb ? b_rd : a_rd, exp);
        if (pb) begin
            check("pdp_b_rdata", pdp_b_rd, exp);
        end else begin
            check("rom_rdata", rom_rd, rom_exp);
        end
    endtask : rd

    // =====================================================================
    // scenarios
    task automatic t_preload;
        rd(1'b0, 14'h0);
        rd(1'b0, 14'h3ff);
        rd(1'b1, 14'h1);
        rd(1'b1, 14'h7ff);
    endtask : t_preload

    task automatic t_byte_enable;
        for (int k = 0; k < 4; k++) begin
            wr(1'b0, 1'b1, 14'h7, {18'h0, 9'h155 ^ 9'(k), 9'h1aa ^ 9'(k)}, 4'(k));
            rd(1'b0, 14'h7);
        end
    endtask : t_byte_enable

    task automatic t_mixed_width;
        wr(1'b1, 1'b1, 14'h14, 36'h1a5, 4'h0);
        wr(1'b1, 1'b1, 14'h15, 36'h05a, 4'h0);
        rd(1'b0, 14'ha);
        // the pseudo dual twin refused both port b writes, so it still holds preload
        check("pdp_a_rdata", pdp_a_rd, {18'h0, INIT_PAT[180 +: 18]});
        wr(1'b0, 1'b1, 14'hc, 36'h2b3c4, 4'h3);
        rd(1'b1, 14'h18);
        rd(1'b1, 14'h19);
    endtask : t_mixed_width

    task automatic t_stage_enables;
        wr(1'b0, 1'b0, 14'h7, 36'h0, 4'h3);
        rd(1'b0, 14'h7);
        port_a_i.set_out_ce(1'b0);
        port_a_i.issue(1'b1, 1'b0, 14'h0, '0, '0);
        repeat (2) @(posedge i_clk);
        #1;
        check("a_rdata_held", a_rd, get(18, 14'h7));
        port_a_i.set_out_ce(1'b1);
        @(posedge i_clk);
        #1;
        check("a_rdata_late", a_rd, get(18, 14'h0));
    endtask : t_stage_enables

    task automatic t_dual_ports;
        fork
            wr(1'b0, 1'b1, 14'h1e, 36'h3c0f0, 4'h3);
            wr(1'b1, 1'b1, 14'h3e, 36'h0f3, 4'h0);
        join
        fork
            rd(1'b0, 14'h1f);
            rd(1'b1, 14'h3c);
        join
    endtask : t_dual_ports

    task automatic give_verdict;
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // =====================================================================
    // main sequence and watchdog
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_preload();
        t_byte_enable();
        t_mixed_width();
        t_stage_enables();
        t_dual_ports();
        give_verdict();
    end

    // the whole run needs under a hundred cycles; this leaves ample margin
    initial begin
        #40000;
        fails++;
        give_verdict();
    end
endmodule : configurable_block_ram_tb
`default_nettype wire
